// File: rtl/twrc_pkg.sv
// Shared constants, types and the checksum function for the two-wire responder
package twrc_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam int T_LOW100_MS = 25;
   localparam int T_LOW400_MS = 5;
   localparam int T_MEXT_MS = 10;
   localparam int T_LONG_MS = 2000;
   localparam int LOW100_CYC = T_LOW100_MS * MS_CYC;
   localparam int LOW400_CYC = T_LOW400_MS * MS_CYC;
   localparam int MEXT_CYC = T_MEXT_MS * MS_CYC;
   localparam int LONG_CYC = T_LONG_MS * MS_CYC;
   localparam int TMO_CNT_W = 25;

   // ------------------------------------------------------------
   // Addressing and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] DEF_ADDR_W = 8'h10;
   localparam logic RST_TWO_WIRE = 1'b1;
   localparam logic RST_SPEED_400K = 1'b1;
   localparam int BYTE_BITS = 8;

   // ------------------------------------------------------------
   // Checksum
   // ------------------------------------------------------------
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // ------------------------------------------------------------
   // Bus state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_REG = 3'b010,
      ST_WDATA = 3'b011,
      ST_WCRC = 3'b100,
      ST_ACK = 3'b101,
      ST_TX = 3'b110,
      ST_MACK = 3'b111
   } twrc_state_e;

   // MSB first, no final xor
   function automatic logic [7:0] crc8_upd(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

endpackage

// File: rtl/twrc_regmem.sv
// Small register memory behind the responder, registered read data
`timescale 1ns/1ns
module twrc_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ------------------------------------------------------------
   // Storage; no reset on the array, it holds settings data only
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // twrc_regmem

// File: rtl/twrc_responder.sv
// Two-wire bus responder with optional checksum, timeouts and interface selection
// Function
// - Answer at 0x10/0x11, address configurable
// - Up to 400 kHz, checksum optional
// - Unprogrammed: two-wire at 400 kHz after reset
// - Speed change applies at edit-mode exit
// - Switch-to-two-wire command acts immediately
// - 100 kHz: clock low 25-35 ms resets
// - 100 kHz: cumulative stretch/extend limits reset
// - 400 kHz: clock low 5-20 ms resets
// - Clock low over 2 s always resets
// - Block writes, register address auto-increments
// - Single write checksum: address, register, data
// - Later block-write bytes: checksum over data only
// - Polynomial x^8+x^2+x+1, initial zero
// - Bad write checksum: not-acknowledge, go idle
// - Reads with or without repeated start
// - Block read: controller acks, address increments
// - Single read checksum runs from first start
// - Read checksum restarts per byte and stop
// - Controller nacks read checksum: go idle
// - Switch-to-four-wire command leaves two-wire mode
`timescale 1ns/1ns
module twrc_responder #(
   parameter int unsigned LOW100_CYC = twrc_pkg::LOW100_CYC,
   parameter int unsigned LOW400_CYC = twrc_pkg::LOW400_CYC,
   parameter int unsigned MEXT_CYC = twrc_pkg::MEXT_CYC,
   parameter int unsigned LONG_CYC = twrc_pkg::LONG_CYC,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic cfg_crc_en,
   input wire logic cfg_timeout_en,
   input wire logic cfg_speed_400k,
   input wire logic cfg_addr_set,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_update_mode,
   input wire logic nvm_programmed,
   input wire logic nvm_two_wire,
   input wire logic nvm_speed_400k,
   input wire logic switch_to_two_wire_cmd,
   input wire logic switch_to_four_wire_cmd,
   output logic two_wire_sel,
   output logic speed_400k_act,
   output logic bus_reset_evt
);

   localparam int CW = twrc_pkg::TMO_CNT_W;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      logic scl_f;
      logic sda_f;
      logic strap_done;
      logic two_wire;
      logic spd400;
      logic cfg_upd_d;
      twrc_pkg::twrc_state_e st;
      twrc_pkg::twrc_state_e after;
      logic [3:0] bitcnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic tx_is_crc;
      logic [AW-1:0] reg_addr;
      logic [7:0] wdata;
      logic [7:0] crc;
      logic [7:0] crc_exp;
      logic in_txn;
      logic mack_ok;
      logic drive;
      logic [CW-1:0] low_cnt;
      logic [CW-1:0] mext_cnt;
      logic rst_evt;
   } twrc_regs_s;

   twrc_regs_s r;
   twrc_regs_s next_r;
   logic [7:0] rd_data;
   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic [7:0] mem_wdata;

   // ------------------------------------------------------------
   // Register memory
   // ------------------------------------------------------------
   twrc_regmem #(
      .AW(AW),
      .DW(8)
   ) u_mem (
      .clk(clk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(r.reg_addr),
      .rd_data(rd_data)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic tmo;
      logic [6:0] my_addr;
      logic [7:0] b;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      tmo = 1'b0;
      my_addr = 7'h00;
      b = 8'h00;
      next_r = r;
      mem_we = 1'b0;
      mem_waddr = r.reg_addr;
      mem_wdata = r.wdata;
      next_r.rst_evt = 1'b0;

      // Three-stage sampling; a level counts once stages two and three agree
      next_r.scl_s1 = scl_i;
      next_r.scl_s2 = r.scl_s1;
      next_r.scl_s3 = r.scl_s2;
      next_r.sda_s1 = sda_i;
      next_r.sda_s2 = r.sda_s1;
      next_r.sda_s3 = r.sda_s2;
      if (r.scl_s2 == r.scl_s3) begin
         next_r.scl_f = r.scl_s3;
      end
      if (r.sda_s2 == r.sda_s3) begin
         next_r.sda_f = r.sda_s3;
      end
      scl_rise = next_r.scl_f & ~r.scl_f;
      scl_fall = ~next_r.scl_f & r.scl_f;
      start_c = r.scl_f & next_r.scl_f & r.sda_f & ~next_r.sda_f;
      stop_c = r.scl_f & next_r.scl_f & ~r.sda_f & next_r.sda_f;

      // ------------------------------------------------------------
      // Interface selection and speed
      // ------------------------------------------------------------
      next_r.strap_done = 1'b1;
      if (!r.strap_done && nvm_programmed) begin
         next_r.two_wire = nvm_two_wire;
         next_r.spd400 = nvm_speed_400k;
      end
      next_r.cfg_upd_d = cfg_update_mode;
      if (r.cfg_upd_d && !cfg_update_mode) begin
         next_r.spd400 = cfg_speed_400k;
      end
      if (switch_to_two_wire_cmd) begin
         next_r.two_wire = 1'b1;
      end else if (switch_to_four_wire_cmd && r.two_wire) begin
         next_r.two_wire = 1'b0;
      end

      // ------------------------------------------------------------
      // Timeouts
      // ------------------------------------------------------------
      // Counters saturate so a stuck bus cannot wrap into a false second event
      if (r.scl_f || !r.two_wire) begin
         next_r.low_cnt = '0;
      end else if (r.low_cnt != '1) begin
         next_r.low_cnt = r.low_cnt + CW'(1);
      end
      // Controller low extension is summed per byte; this end never stretches the clock
      if (r.st == twrc_pkg::ST_IDLE || r.st == twrc_pkg::ST_ACK || r.st == twrc_pkg::ST_MACK) begin
         next_r.mext_cnt = '0;
      end else if (!r.scl_f && r.mext_cnt != '1) begin
         next_r.mext_cnt = r.mext_cnt + CW'(1);
      end
      if (r.low_cnt == CW'(LONG_CYC)) begin
         tmo = 1'b1;
      end
      if (cfg_timeout_en && r.spd400 && r.low_cnt == CW'(LOW400_CYC)) begin
         tmo = 1'b1;
      end
      if (cfg_timeout_en && !r.spd400 && r.low_cnt == CW'(LOW100_CYC)) begin
         tmo = 1'b1;
      end
      if (cfg_timeout_en && !r.spd400 && r.mext_cnt == CW'(MEXT_CYC)) begin
         tmo = 1'b1;
      end

      my_addr = cfg_addr_set ? cfg_addr[7:1] : twrc_pkg::DEF_ADDR_W[7:1];
      b = r.sh;

      // ------------------------------------------------------------
      // Bus state machine
      // ------------------------------------------------------------
      if (!r.two_wire || tmo) begin
         next_r.st = twrc_pkg::ST_IDLE;
         next_r.drive = 1'b0;
         next_r.in_txn = 1'b0;
         next_r.crc = twrc_pkg::CRC_INIT;
         next_r.rst_evt = tmo;
      end else if (stop_c) begin
         next_r.st = twrc_pkg::ST_IDLE;
         next_r.drive = 1'b0;
         next_r.in_txn = 1'b0;
         next_r.crc = twrc_pkg::CRC_INIT;
      end else if (start_c) begin
         next_r.st = twrc_pkg::ST_ADDR;
         next_r.bitcnt = 4'h0;
         next_r.drive = 1'b0;
         next_r.in_txn = 1'b1;
         // Repeated start keeps the running checksum
         next_r.crc = r.in_txn ? r.crc : twrc_pkg::CRC_INIT;
      end else begin
         case (r.st)
            twrc_pkg::ST_ADDR, twrc_pkg::ST_REG, twrc_pkg::ST_WDATA, twrc_pkg::ST_WCRC: begin
               if (scl_rise && r.bitcnt != 4'(twrc_pkg::BYTE_BITS)) begin
                  next_r.sh = {r.sh[6:0], next_r.sda_f};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == 4'(twrc_pkg::BYTE_BITS)) begin
                  next_r.bitcnt = 4'h0;
                  next_r.drive = 1'b1;
                  next_r.st = twrc_pkg::ST_ACK;
                  if (r.st == twrc_pkg::ST_ADDR) begin
                     if (b[7:1] != my_addr) begin
                        next_r.drive = 1'b0;
                        next_r.st = twrc_pkg::ST_IDLE;
                     end else begin
                        next_r.crc = twrc_pkg::crc8_upd(r.crc, b);
                        next_r.after = b[0] ? twrc_pkg::ST_TX : twrc_pkg::ST_REG;
                     end
                  end else if (r.st == twrc_pkg::ST_REG) begin
                     next_r.reg_addr = b[AW-1:0];
                     next_r.crc = twrc_pkg::crc8_upd(r.crc, b);
                     next_r.after = twrc_pkg::ST_WDATA;
                  end else if (r.st == twrc_pkg::ST_WDATA) begin
                     if (cfg_crc_en) begin
                        next_r.wdata = b;
                        next_r.crc_exp = twrc_pkg::crc8_upd(r.crc, b);
                        next_r.after = twrc_pkg::ST_WCRC;
                     end else begin
                        mem_we = 1'b1;
                        mem_wdata = b;
                        next_r.reg_addr = r.reg_addr + AW'(1);
                        next_r.after = twrc_pkg::ST_WDATA;
                     end
                  end else begin
                     if (b == r.crc_exp) begin
                        mem_we = 1'b1;
                        next_r.reg_addr = r.reg_addr + AW'(1);
                        next_r.crc = twrc_pkg::CRC_INIT;
                        next_r.after = twrc_pkg::ST_WDATA;
                     end else begin
                        next_r.drive = 1'b0;
                        next_r.st = twrc_pkg::ST_IDLE;
                     end
                  end
               end
            end
            twrc_pkg::ST_ACK: begin
               if (scl_fall) begin
                  next_r.drive = 1'b0;
                  next_r.bitcnt = 4'h0;
                  next_r.st = r.after;
                  if (r.after == twrc_pkg::ST_TX) begin
                     next_r.tx = rd_data;
                     next_r.tx_is_crc = 1'b0;
                     next_r.drive = ~rd_data[7];
                     next_r.crc = twrc_pkg::crc8_upd(r.crc, rd_data);
                     next_r.reg_addr = r.reg_addr + AW'(1);
                  end
               end
            end
            twrc_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r.bitcnt == 4'(twrc_pkg::BYTE_BITS - 1)) begin
                     next_r.drive = 1'b0;
                     next_r.bitcnt = 4'h0;
                     next_r.mack_ok = 1'b0;
                     next_r.st = twrc_pkg::ST_MACK;
                  end else begin
                     next_r.tx = {r.tx[6:0], 1'b0};
                     next_r.drive = ~r.tx[6];
                     next_r.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end
            twrc_pkg::ST_MACK: begin
               if (scl_rise) begin
                  next_r.mack_ok = ~next_r.sda_f;
                  if (next_r.sda_f) begin
                     // Nack ends the read and returns to idle, whether it follows a data byte or a checksum byte
                     next_r.st = twrc_pkg::ST_IDLE;
                  end
               end else if (scl_fall && r.mack_ok) begin
                  next_r.st = twrc_pkg::ST_TX;
                  if (cfg_crc_en && !r.tx_is_crc) begin
                     next_r.tx = r.crc;
                     next_r.tx_is_crc = 1'b1;
                     next_r.drive = ~r.crc[7];
                  end else begin
                     next_r.tx = rd_data;
                     next_r.tx_is_crc = 1'b0;
                     next_r.drive = ~rd_data[7];
                     next_r.crc = twrc_pkg::crc8_upd(twrc_pkg::CRC_INIT, rd_data);
                     next_r.reg_addr = r.reg_addr + AW'(1);
                  end
               end
            end
            default: begin
               next_r.drive = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
         r.scl_s1 <= 1'b1;
         r.scl_s2 <= 1'b1;
         r.scl_s3 <= 1'b1;
         r.sda_s1 <= 1'b1;
         r.sda_s2 <= 1'b1;
         r.sda_s3 <= 1'b1;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.two_wire <= twrc_pkg::RST_TWO_WIRE;
         r.spd400 <= twrc_pkg::RST_SPEED_400K;
         r.st <= twrc_pkg::ST_IDLE;
         r.after <= twrc_pkg::ST_IDLE;
         r.crc <= twrc_pkg::CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = r.drive;
   assign two_wire_sel = r.two_wire;
   assign speed_400k_act = r.spd400;
   assign bus_reset_evt = r.rst_evt;

endmodule // twrc_responder

// File: tb/twrc_host.sv
// Bus controller model driving the clock and data lines of the responder
`timescale 1ns/1ns
module twrc_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // --------
   // Line drivers
   // --------
   // Clock stands high between frames; data is only ever pulled low
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Data moves late in the low phase so the responder always sees the clock fall first
   task automatic bit_io(input logic b, output logic r);
      #400 sda_low = !b;
      #200 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
   endtask
   // MSB first, then the acknowledge slot; ack_in low acknowledges read data
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask
   task automatic start();
      #400 sda_low = 1'b0;
      #200 scl = 1'b1;
      #400 sda_low = 1'b1;
      #400 scl = 1'b0;
   endtask
   task automatic stop();
      #400 sda_low = 1'b1;
      #200 scl = 1'b1;
      #400 sda_low = 1'b0;
      #400;
   endtask
   task automatic low(input int ns);
      scl = 1'b0;
      #(ns) scl = 1'b1;
   endtask
endmodule // twrc_host

// File: tb/twrc_responder_properties.sv
// Concurrent checks on the ports of the two-wire responder
`timescale 1ns/1ns
module twrc_responder_props #(
   parameter int unsigned LOW100_CYC = 200,
   parameter int unsigned LOW400_CYC = 100,
   parameter int unsigned LONG_CYC = 600
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic cfg_timeout_en,
   input wire logic cfg_update_mode,
   input wire logic switch_to_two_wire_cmd,
   input wire logic switch_to_four_wire_cmd,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic two_wire_sel,
   input wire logic speed_400k_act,
   input wire logic bus_reset_evt
);
   // --------
   // Clock-low tracking
   // --------
   // Raw pin time; the margin of 8 covers the input sampler delay
   logic [15:0] low_cnt;
   logic seen;
   always_ff @(posedge clk) begin
      if (!resetn || scl_i) begin
         low_cnt <= 16'h0000;
         seen <= 1'b0;
      end else begin
         if (low_cnt != 16'hFFFF) begin
            low_cnt <= low_cnt + 16'h0001;
         end
         if (bus_reset_evt) begin
            seen <= 1'b1;
         end
      end
   end
   // --------
   // Properties
   // --------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence edit_held;
      $past(resetn, 4) && cfg_update_mode ##1 cfg_update_mode;
   endsequence
   sequence off_held;
      !two_wire_sel ##1 !two_wire_sel;
   endsequence
   chk_reset_out: assert property (disable iff (1'b0) !resetn |=> two_wire_sel && speed_400k_act && !sda_oe)
      else $error("outputs not at reset values");
   chk_drive_low: assert property (sda_o == 1'b0)
      else $error("data output value not low");
   chk_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data drive changed while clock high");
   chk_edit_hold: assert property (edit_held |=> $stable(speed_400k_act))
      else $error("speed changed inside edit mode");
   chk_two_on: assert property (switch_to_two_wire_cmd |=> two_wire_sel)
      else $error("two-wire not selected after command");
   chk_four_off: assert property (switch_to_four_wire_cmd && !switch_to_two_wire_cmd |=> !two_wire_sel)
      else $error("two-wire still selected after four-wire command");
   chk_off_quiet: assert property (off_held |-> !sda_oe)
      else $error("data driven while deselected");
   chk_evt_pulse: assert property (bus_reset_evt |=> !bus_reset_evt)
      else $error("reset event longer than one cycle");
   chk_slow_tmo: assert property (cfg_timeout_en && !speed_400k_act && two_wire_sel
      && low_cnt == 16'(LOW100_CYC + 8) |-> seen)
      else $error("slow clock-low timeout missed");
   chk_fast_tmo: assert property (cfg_timeout_en && speed_400k_act && two_wire_sel
      && low_cnt == 16'(LOW400_CYC + 8) |-> seen)
      else $error("fast clock-low timeout missed");
   chk_long_tmo: assert property (two_wire_sel && low_cnt == 16'(LONG_CYC + 8) |-> seen)
      else $error("long clock-low timeout missed");
endmodule // twrc_responder_props

// File: tb/twrc_responder_test.sv
// Self-checking bench for the two-wire responder
`timescale 1ns/1ns
module twrc_responder_test;
   // --------
   // Design and model
   // --------
   // Short timeout counts keep the run brief; all holds derive from these
   localparam int L100 = 200;
   localparam int L400 = 100;
   localparam int LONG = 600;
   localparam int MEXT = 150;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic crc_en = 1'b1;
   logic tmo_en = 1'b1;
   logic spd = 1'b1;
   logic addr_set = 1'b0;
   logic [7:0] addr = 8'h40;
   logic upd = 1'b0;
   logic sw2 = 1'b0;
   logic sw4 = 1'b0;
   logic nvm = 1'b0;
   logic scl, sda_low, sda_o, sda_oe, sel, spd_act, evt;
   logic [7:0] c1;
   int fails = 0;
   int checks_done = 0;
   int evts = 0;
   // Pull-up on the shared data line
   wire sda = !(sda_low || sda_oe);
   always #50 clk = ~clk;
   always @(posedge clk) if (evt === 1'b1) evts <= evts + 1;
   twrc_host u_host (.scl(scl), .sda_low(sda_low), .sda(sda));
   twrc_responder #(.LOW100_CYC(L100), .LOW400_CYC(L400), .MEXT_CYC(MEXT), .LONG_CYC(LONG)) dut (
      .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .cfg_crc_en(crc_en), .cfg_timeout_en(tmo_en), .cfg_speed_400k(spd), .cfg_addr_set(addr_set),
      .cfg_addr(addr), .cfg_update_mode(upd), .nvm_programmed(nvm), .nvm_two_wire(1'b0),
      .nvm_speed_400k(1'b0), .switch_to_two_wire_cmd(sw2), .switch_to_four_wire_cmd(sw4),
      .two_wire_sel(sel), .speed_400k_act(spd_act), .bus_reset_evt(evt));
   // --------
   // Tasks
   // --------
   function automatic logic [7:0] f(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
      return r;
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic [7:0] q;
      logic a;
      u_host.xfer(b, 1'b1, q, a);
      chk("ack", {7'h00, !exp_ack}, {7'h00, a});
   endtask
   task automatic get(input logic [7:0] exp, input logic last);
      logic [7:0] q;
      logic a;
      u_host.xfer(8'hFF, last, q, a);
      chk("read byte", exp, q);
   endtask
   task automatic wr(input logic [7:0] b[$], input int nak_at);
      u_host.start();
      foreach (b[i]) put(b[i], i != nak_at);
      u_host.stop();
   endtask
   task automatic rd(input logic [7:0] rg, input logic rs, input logic [7:0] exp[$]);
      u_host.start();
      put(8'h10, 1'b1);
      put(rg, 1'b1);
      if (!rs) u_host.stop();
      u_host.start();
      put(8'h11, 1'b1);
      foreach (exp[i]) get(exp[i], i == exp.size() - 1);
      u_host.stop();
   endtask
   task automatic swap(input logic to_two);
      sw2 = to_two;
      sw4 = !to_two;
      step(1);
      sw2 = 1'b0;
      sw4 = 1'b0;
      step(1);
      chk("two-wire select", {7'h00, to_two}, {7'h00, sel});
   endtask
   // Expected event count is exact: below the limit none, above it one
   task automatic hold(input int n, input int exp);
      int e0;
      e0 = evts;
      u_host.low(n * 100);
      step(10);
      chk("reset events", 8'(exp), 8'(evts - e0));
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // --------
   // Main sequence
   // --------
   initial begin
      step(16);
      resetn = 1'b1;
      step(10);
      chk("two-wire select", 8'h01, {7'h00, sel});
      chk("speed", 8'h01, {7'h00, spd_act});
      c1 = f(f(8'h00, 8'h10), 8'h20);
      wr({8'h10, 8'h20, 8'hA5, f(c1, 8'hA5), 8'h3C, f(8'h00, 8'h3C)}, 9);
      rd(8'h20, 1'b1, {8'hA5, f(f(c1, 8'h11), 8'hA5), 8'h3C, f(8'h00, 8'h3C)});
      rd(8'h21, 1'b0, {8'h3C, f(f(8'h00, 8'h11), 8'h3C)});
      wr({8'h10, 8'h22, 8'h5A, ~f(f(f(8'h00, 8'h10), 8'h22), 8'h5A)}, 3);
      crc_en = 1'b0;
      wr({8'h10, 8'h40, 8'h77}, 9);
      rd(8'h40, 1'b1, {8'h77});
      wr({8'h12}, 0);
      addr_set = 1'b1;
      wr({8'h40, 8'h41, 8'h99}, 9);
      wr({8'h10}, 0);
      addr_set = 1'b0;
      swap(1'b0);
      wr({8'h10}, 0);
      swap(1'b1);
      rd(8'h41, 1'b1, {8'h99});
      hold(L400 - 20, 0);
      hold(L400 + 20, 1);
      upd = 1'b1;
      spd = 1'b0;
      step(4);
      chk("speed", 8'h01, {7'h00, spd_act});
      upd = 1'b0;
      step(4);
      chk("speed", 8'h00, {7'h00, spd_act});
      hold(L100 - 20, 0);
      hold(L100 + 20, 1);
      // Two lows inside one byte, each short of the single limit, together past the sum limit
      u_host.start();
      put(8'h10, 1'b1);
      hold(MEXT - 30, 0);
      hold(MEXT - 30, 1);
      tmo_en = 1'b0;
      hold(LONG - 20, 0);
      hold(LONG + 20, 1);
      // Programmed straps differ from the defaults, so only a programmed part may take them
      resetn = 1'b0;
      nvm = 1'b1;
      step(4);
      resetn = 1'b1;
      step(10);
      chk("two-wire select", 8'h00, {7'h00, sel});
      chk("speed", 8'h00, {7'h00, spd_act});
      summarize();
   end
endmodule // twrc_responder_test

bind twrc_responder twrc_responder_props #(.LOW100_CYC(LOW100_CYC), .LOW400_CYC(LOW400_CYC), .LONG_CYC(LONG_CYC))
   u_props (.clk, .resetn, .scl_i, .cfg_timeout_en, .cfg_update_mode, .switch_to_two_wire_cmd,
   .switch_to_four_wire_cmd, .sda_o, .sda_oe, .two_wire_sel, .speed_400k_act, .bus_reset_evt);
